// ### dv/video_port_select_router_bench.sv
`timescale 1ns/100ps
module video_port_select_router_bench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic        pready, pslverr, e, sink_hotplug_in = 0;
	logic        low_power_select_n = 1, control_mode_select = 0;
	logic        port_select_low_bit = 0, port_select_high_bit = 0;
	logic [3:0]  port_power_sense = 0, port_clock_valid = 0;
	logic [3:0]  port_hotplug_out, port_term_en, port_scl_oe, port_sda_oe;
	logic        selected_power_indicator, irq_out, outputs_oe;
	logic        sink_scl_oe, sink_sda_oe, sink_scl_in, sink_sda_in;
	logic [3:0]  port_scl_in, port_sda_in;
	logic        rx_scl_low = 0, rx_sda_low = 0;
	logic [3:0]  src_scl_low = 0, src_sda_low = 0;
	logic [1:0]  sel;
	int          failures = 0, n_checks = 0;
	wire  [31:0] outs = {21'h0, outputs_oe, port_term_en, port_hotplug_out,
		selected_power_indicator, irq_out};

	////////////////////////////////////////////////////////////////////////
	always #5 pclk = ~pclk;

	vpsr_top i_vpsr_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .low_power_select_n,
		.control_mode_select, .port_select_low_bit, .port_select_high_bit,
		.sink_hotplug_in, .port_power_sense, .port_clock_valid,
		.port_hotplug_out, .selected_power_indicator, .irq_out, .outputs_oe,
		.port_term_en, .sink_scl_in, .sink_scl_out(), .sink_scl_oe,
		.sink_sda_in, .sink_sda_out(), .sink_sda_oe, .port_scl_in,
		.port_scl_out(), .port_scl_oe, .port_sda_in, .port_sda_out(),
		.port_sda_oe);

	vpsr_far_side i_vpsr_far_side (.sink_scl_oe, .sink_sda_oe, .port_scl_oe,
		.port_sda_oe, .rx_scl_low, .rx_sda_low, .src_scl_low, .src_sda_low,
		.sink_scl_in, .sink_sda_in, .port_scl_in, .port_sda_in);

	////////////////////////////////////////////////////////////////////////
	// Expected routed outputs: oe, terminations, hot-plug, indicator, irq
	function automatic logic [31:0] expect_out(logic [1:0] s, logic md);
		logic [3:0] oh;
		oh = 4'h1 << s;
		return 32'({1'b1, oh, (port_power_sense & ~oh) |
			(sink_hotplug_in ? oh : 4'h0), port_power_sense[s],
			md ? 1'b0 : port_clock_valid[s]});
	endfunction

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Whole transfer; request held until pready is sampled high
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Pins cross up to three flops, so wait whole edges then step off the edge
	task automatic settle(int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	task automatic summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the roughly 120 cycles the tests need
	initial begin
		repeat (3000) @(posedge pclk);
		failures++;
		summarize();
	end

	// Main sequence
	initial begin
		void'($urandom(32'hEF963EF4));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h004, 32'h0);
		chk("status", 32'h2, q);
		apb(1'b1, 12'h010, 32'h3);
		chk("slverr", 32'h1, 32'(e));
		for (int i = 0; i < 12; i++) begin
			sel = 2'(i);
			{port_select_high_bit, port_select_low_bit} <= sel;
			port_power_sense <= 4'($urandom);
			sink_hotplug_in <= 1'($urandom);
			port_clock_valid <= 4'($urandom);
			settle(4);
			chk("route", expect_out(sel, 1'b0),
				outs);
		end
		// Receiver holds clock low, selected source holds data low
		rx_scl_low <= 1'b1;
		src_sda_low <= 4'h1 << sel;
		settle(2);
		chk("ddc", 32'({4'h1 << sel, 6'h1}),
			32'({port_scl_oe, port_sda_oe, sink_scl_oe, sink_sda_oe}));
		rx_scl_low <= 1'b0;
		src_sda_low <= 4'h0;
		settle(3);
		chk("ddc_free", 32'h0,
			32'({port_scl_oe, port_sda_oe, sink_scl_oe, sink_sda_oe}));
		control_mode_select <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			sel = 2'(i);
			{port_select_high_bit, port_select_low_bit} <= ~sel;
			apb(1'b1, 12'h000, 32'(sel));
			settle(4);
			chk("regmode", expect_out(sel, 1'b1), outs);
			apb(1'b0, 12'h004, 32'h0);
			chk("stat_sel", 32'({sel, 1'b1}), 32'({q[11:10], q[2]}));
		end
		low_power_select_n <= 1'b0;
		apb(1'b1, 12'h000, 32'h1);
		settle(2);
		chk("lowpwr", 32'h0, outs);
		low_power_select_n <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl_kept", 32'h3, q);
		summarize();
	end
endmodule

// ### dv/vpsr_far_side.sv
`timescale 1ns/100ps
// Sources and display receiver on the open-drain control lines
module vpsr_far_side (
	// Pull-low enables of the design
	input  wire logic       sink_scl_oe,
	input  wire logic       sink_sda_oe,
	input  wire logic [3:0] port_scl_oe,
	input  wire logic [3:0] port_sda_oe,
	// Far side pulls, set by the bench
	input  wire logic       rx_scl_low,
	input  wire logic       rx_sda_low,
	input  wire logic [3:0] src_scl_low,
	input  wire logic [3:0] src_sda_low,
	// Resolved wire levels
	output logic            sink_scl_in,
	output logic            sink_sda_in,
	output logic      [3:0] port_scl_in,
	output logic      [3:0] port_sda_in
);
	// Wired-AND; pull-ups make a released line read high, never stale
	assign sink_scl_in = ~(sink_scl_oe | rx_scl_low);
	assign sink_sda_in = ~(sink_sda_oe | rx_sda_low);
	assign port_scl_in = ~(port_scl_oe | src_scl_low);
	assign port_sda_in = ~(port_sda_oe | src_sda_low);
endmodule

// ### src/vpsr_pkg.sv
package vpsr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses on the APB)
	localparam int          ADDR_W        = 12;
	localparam logic [11:0] CTRL_OFFSET   = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;

	// Control register fields
	localparam int          CTRL_SEL_LSB  = 0;
	localparam logic [1:0]  CTRL_SEL_RST  = 2'h0;

	// Number of video ports and synchroniser width
	localparam int          NUM_PORTS     = 4;
	localparam int          SYNC_W        = 7;

	// Raw pin bundle order inside the synchroniser vector
	localparam int          SY_PWR_LSB    = 0;
	localparam int          SY_SINK_HPD   = 4;
	localparam int          SY_SEL_LSB    = 5;

	////////////////////////////////////////////////////////////////////////
	// Status word as read back by software
	typedef struct packed {
		logic [19:0] zero;
		logic [1:0]  active_port;
		logic        power_ind;
		logic        irq;
		logic [3:0]  power_sense;
		logic        sink_hotplug;
		logic        reg_mode;
		logic        awake;
		logic        reserved;
	} vpsr_status_t;

	// Two select bits to a one-hot port vector, port 1 in bit 0
	function automatic logic [3:0] port_onehot(input logic [1:0] sel);
		port_onehot = 4'h1 << sel;
	endfunction

endpackage

// ### src/vpsr_top.sv
//
// Operation
// RULE1: Select pins decode binary to ports one to four
// RULE2: Only the selected port keeps terminations
// RULE3: Sink control lines join the selected port only
// RULE4: Selected port hot-plug follows sink hot-plug
// RULE5: Unselected port hot-plug follows own power sense
// RULE6: Power indicator shows selected port power sense
// RULE7: Low-power input low turns everything off
// RULE8: Pins select only while control-mode input low
// RULE9: Pin mode interrupt shows selected clock valid
// RULE10: Select and sense pins pass two-stage synchronisers
`timescale 1ns/100ps
module vpsr_top (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Mode and selection pins
	input  wire logic        low_power_select_n,
	input  wire logic        control_mode_select,
	input  wire logic        port_select_low_bit,
	input  wire logic        port_select_high_bit,
	// Status inputs
	input  wire logic        sink_hotplug_in,
	input  wire logic [3:0]  port_power_sense,
	input  wire logic [3:0]  port_clock_valid,
	// Routed status outputs
	output logic      [3:0]  port_hotplug_out,
	output logic             selected_power_indicator,
	output logic             irq_out,
	output logic             outputs_oe,
	output logic      [3:0]  port_term_en,
	// Sink side control lines, open drain
	input  wire logic        sink_scl_in,
	output logic             sink_scl_out,
	output logic             sink_scl_oe,
	input  wire logic        sink_sda_in,
	output logic             sink_sda_out,
	output logic             sink_sda_oe,
	// Port side control lines, open drain
	input  wire logic [3:0]  port_scl_in,
	output logic      [3:0]  port_scl_out,
	output logic      [3:0]  port_scl_oe,
	input  wire logic [3:0]  port_sda_in,
	output logic      [3:0]  port_sda_out,
	output logic      [3:0]  port_sda_oe
);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic [6:0]  sync1_ff, sync2_ff;
	logic [1:0]  ctrl_sel_ff;
	logic [31:0] prdata_ff;
	logic [3:0]  hpd_ff, term_ff;
	logic        pind_ff, irq_ff, oe_ff;
	logic [3:0]  pscl_oe_ff, psda_oe_ff;
	logic        sscl_oe_ff, ssda_oe_ff;
	vpsr_pkg::vpsr_status_t status;

	wire  [6:0]  raw_pins   = {port_select_high_bit, port_select_low_bit,
		sink_hotplug_in, port_power_sense};
	wire  [1:0]  pin_sel    = sync2_ff[vpsr_pkg::SY_SEL_LSB +: 2];
	wire         sink_hpd   = sync2_ff[vpsr_pkg::SY_SINK_HPD];
	wire  [3:0]  pwr_sense  = sync2_ff[vpsr_pkg::SY_PWR_LSB +: 4];
	wire         awake      = low_power_select_n;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage one feeds stage two only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_ff <= 7'h00;
			sync2_ff <= 7'h00;
		end else begin
			sync1_ff <= raw_pins; // RULE10
			sync2_ff <= sync1_ff; // RULE10
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Port selection: pins in pin mode, register in register mode
	wire  [1:0]  act_sel    = control_mode_select ? ctrl_sel_ff : pin_sel; // RULE8
	wire  [3:0]  act_oh     = vpsr_pkg::port_onehot(act_sel); // RULE1
	wire  [3:0]  act_mask   = awake ? act_oh : 4'h0; // RULE7

	// Next values of routed outputs; all forced quiet in low power
	wire  [3:0]  nxt_term   = act_mask; // RULE2
	wire  [3:0]  nxt_hpd    = awake ? ((act_oh & {4{sink_hpd}}) // RULE4
		| (~act_oh & pwr_sense)) : 4'h0; // RULE5
	wire         nxt_pind   = |(act_mask & pwr_sense); // RULE6
	wire         nxt_irq    = !control_mode_select
		& |(act_mask & port_clock_valid); // RULE9

	// Control line repeater; a side is only mirrored if we are not the
	// ones pulling it low, which keeps the two halves from latching up
	wire  [3:0]  nxt_pscl   = act_mask & {4{~sink_scl_in & ~sscl_oe_ff}};
	wire  [3:0]  nxt_psda   = act_mask & {4{~sink_sda_in & ~ssda_oe_ff}};
	wire         nxt_sscl   = |(act_mask & ~port_scl_in & ~pscl_oe_ff);
	wire         nxt_ssda   = |(act_mask & ~port_sda_in & ~psda_oe_ff);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			term_ff    <= 4'h0;
			hpd_ff     <= 4'h0;
			pind_ff    <= 1'b0;
			irq_ff     <= 1'b0;
			oe_ff      <= 1'b0;
			pscl_oe_ff <= 4'h0;
			psda_oe_ff <= 4'h0;
			sscl_oe_ff <= 1'b0;
			ssda_oe_ff <= 1'b0;
		end else begin
			term_ff    <= nxt_term;
			hpd_ff     <= nxt_hpd;
			pind_ff    <= nxt_pind;
			irq_ff     <= nxt_irq;
			oe_ff      <= awake; // RULE7
			pscl_oe_ff <= nxt_pscl; // RULE3
			psda_oe_ff <= nxt_psda; // RULE3
			sscl_oe_ff <= nxt_sscl; // RULE3
			ssda_oe_ff <= nxt_ssda; // RULE3
		end
	end

	assign port_term_en             = term_ff;
	assign port_hotplug_out         = hpd_ff;
	assign selected_power_indicator = pind_ff;
	assign irq_out                  = irq_ff;
	assign outputs_oe               = oe_ff;
	assign port_scl_oe              = pscl_oe_ff;
	assign port_sda_oe              = psda_oe_ff;
	assign sink_scl_oe              = sscl_oe_ff;
	assign sink_sda_oe              = ssda_oe_ff;
	assign port_scl_out             = 4'h0;
	assign port_sda_out             = 4'h0;
	assign sink_scl_out             = 1'b0;
	assign sink_sda_out             = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, read data prepared in the setup cycle
	wire         hit_ctrl   = paddr == vpsr_pkg::CTRL_OFFSET;
	wire         hit_status = paddr == vpsr_pkg::STATUS_OFFSET;
	wire         setup_rd   = psel & ~penable & ~pwrite;
	wire         ctrl_wr    = psel & penable & pwrite & hit_ctrl & awake;

	always_comb begin
		status              = '0;
		status.active_port  = act_sel;
		status.power_ind    = pind_ff;
		status.irq          = irq_ff;
		status.power_sense  = pwr_sense;
		status.sink_hotplug = sink_hpd;
		status.reg_mode     = control_mode_select;
		status.awake        = awake;
	end

	wire  [31:0] rd_word    = hit_ctrl ? {30'h0, ctrl_sel_ff} :
		hit_status ? status : 32'h0000_0000;

	// Writes are ignored in low power since all controls are ignored then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_sel_ff <= vpsr_pkg::CTRL_SEL_RST;
			prdata_ff   <= 32'h0000_0000;
		end else begin
			if (ctrl_wr)
				ctrl_sel_ff <= pwdata[vpsr_pkg::CTRL_SEL_LSB +: 2];
			if (setup_rd)
				prdata_ff <= rd_word;
		end
	end

	assign prdata  = prdata_ff;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~(hit_ctrl | hit_status);

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Flops are still held in reset at the release edge, so each antecedent
	// apart from those of term_onehot_a and low_pwr_a also needs reset sampled high to avoid a false fire there
	sequence pin_mode_awake;
		presetn && awake && !control_mode_select;
	endsequence

	sequence routed_next;
		##1 term_ff == $past(vpsr_pkg::port_onehot(pin_sel));
	endsequence

	sel_decode_a: assert property (pin_mode_awake |-> routed_next) // RULE1
		else $error("port select decode wrong");
	term_onehot_a: assert property ( // RULE2
		oe_ff |-> $onehot(term_ff)) else $error("terminations not one-hot");
	ddc_route_a: assert property ( // RULE3
		presetn && awake && !sink_scl_in && !sscl_oe_ff |=>
		pscl_oe_ff == $past(act_oh)) else $error("scl route wrong");
	hpd_sel_a: assert property ( // RULE4
		presetn && awake |=> ((hpd_ff & $past(act_oh)) ==
		($past(act_oh) & {4{$past(sink_hpd)}}))) else $error("hpd sel bad");
	hpd_unsel_a: assert property ( // RULE5
		presetn && awake |=> ((hpd_ff & ~$past(act_oh)) ==
		(~$past(act_oh) & $past(pwr_sense)))) else $error("hpd unsel bad");
	pwr_ind_a: assert property ( // RULE6
		presetn && awake |=>
		pind_ff == |($past(act_oh) & $past(pwr_sense)))
		else $error("power indicator wrong");
	low_pwr_a: assert property ( // RULE7
		!awake [*2] |-> !oe_ff && term_ff == 4'h0 && hpd_ff == 4'h0
		&& !irq_ff && pscl_oe_ff == 4'h0 && !sscl_oe_ff)
		else $error("low power not quiet");
	reg_mode_a: assert property ( // RULE8
		presetn && awake && control_mode_select |=> term_ff ==
		vpsr_pkg::port_onehot($past(ctrl_sel_ff))) else $error("reg sel bad");
	irq_level_a: assert property ( // RULE9
		pin_mode_awake |=>
		irq_ff == |($past(act_oh) & $past(port_clock_valid)))
		else $error("irq level wrong");
	sync_delay_a: assert property ( // RULE10
		presetn |-> ##2 sync2_ff == $past(raw_pins, 2))
		else $error("sync depth wrong");

endmodule
